// *** src/afs_pin_select.sv ***
`timescale 1ns/10ps
`include "afs_consts.svh"

module afs_pin_select (
  input wire logic clock,
  input wire logic clk_en,
  input wire logic sys_rst,
  input wire logic cfg_state,
  input wire logic idx_wr,
  input wire logic data_wr,
  input wire logic data_rd,
  input wire afs_pkg::afs_byte_t wr_data,
  output afs_pkg::afs_byte_t rd_data,
  output logic rd_valid,
  output logic rd_hit,
  input wire logic [7:0] gpio_out,
  input wire logic [7:0] gpio_oe,
  output logic [7:0] gpio_in,
  input wire logic [7:0] pad_in,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe,
  input wire logic transmit_data_second_or_ir_out,
  input wire logic request_to_send_second_port_n,
  input wire logic terminal_ready_second_port_n,
  output logic ring_indicator_second_port_n,
  output logic carrier_detect_second_port_n,
  output logic receive_data_second_or_ir_in,
  output logic data_set_ready_second_port_n,
  output logic clear_to_send_second_port_n
);
  import afs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  afs_byte_t idx_reg, idx_next;
  afs_byte_t sel9_reg, sel9_next;
  afs_byte_t sel10_reg, sel10_next;
  afs_byte_t rd_data_reg, rd_data_next;
  logic rd_valid_reg, rd_valid_next;
  logic rd_hit_reg, rd_hit_next;
  logic hit9, hit10;

  // Data access uses the index held before this cycle, so an index write in
  // the same cycle only affects later data accesses
  always_comb begin
    hit9 = cfg_state && (idx_reg == `AFS_IDX_SEL9);
    hit10 = cfg_state && (idx_reg == `AFS_IDX_SEL10);
    idx_next = (cfg_state && idx_wr) ? wr_data : idx_reg;
    // Full byte stored, reserved codes included
    sel9_next = (hit9 && data_wr) ? wr_data : sel9_reg;
    sel10_next = (hit10 && data_wr) ? wr_data : sel10_reg;
    rd_valid_next = cfg_state && data_rd;
    rd_hit_next = data_rd && (hit9 || hit10);
    if (data_rd && hit9) begin
      rd_data_next = sel9_reg;
    end else if (data_rd && hit10) begin
      rd_data_next = sel10_reg;
    end else begin
      rd_data_next = `AFS_RD_NONE;
    end
  end

  // Reset acts even with the clock enable low, so a stalled block still
  // comes up with every pin on GPIO
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      idx_reg <= `AFS_IDX_RESET;
      sel9_reg <= `AFS_SEL_RESET;
      sel10_reg <= `AFS_SEL_RESET;
      rd_data_reg <= `AFS_RD_NONE;
      rd_valid_reg <= 1'b0;
      rd_hit_reg <= 1'b0;
    end else if (clk_en) begin
      idx_reg <= idx_next;
      sel9_reg <= sel9_next;
      sel10_reg <= sel10_next;
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
      rd_hit_reg <= rd_hit_next;
    end
  end

  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;
  assign rd_hit = rd_hit_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Pad input synchroniser: a change counts once stages two and three agree

  logic [7:0] sync1_reg, sync2_reg, sync3_reg, pad_lvl_reg;
  logic [7:0] pad_lvl_next;

  always_comb begin
    pad_lvl_next = pad_lvl_reg;
    for (int p = 0; p < 8; p++) begin
      if (sync2_reg[p] == sync3_reg[p]) begin
        pad_lvl_next[p] = sync3_reg[p];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync1_reg <= `AFS_PIN_IDLE;
      sync2_reg <= `AFS_PIN_IDLE;
      sync3_reg <= `AFS_PIN_IDLE;
      pad_lvl_reg <= `AFS_PIN_IDLE;
    end else if (clk_en) begin
      sync1_reg <= pad_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pad_lvl_reg <= pad_lvl_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin steering, registered so every output leaves a flip-flop

  logic [7:0] route_out, route_oe;
  logic ri_c, dcd_c, rxd_c, dsr_c, cts_c;
  logic [7:0] pad_out_reg, pad_oe_reg, gpio_in_reg;
  logic ri_reg, dcd_reg, rxd_reg, dsr_reg, cts_reg;

  afs_pin_route u_route (
    .low_sel(sel9_reg),
    .high_sel(sel10_reg),
    .gpio_out(gpio_out),
    .gpio_oe(gpio_oe),
    .pad_level(pad_lvl_reg),
    .transmit_data_second_or_ir_out(transmit_data_second_or_ir_out),
    .request_to_send_second_port_n(request_to_send_second_port_n),
    .terminal_ready_second_port_n(terminal_ready_second_port_n),
    .pad_out(route_out),
    .pad_oe(route_oe),
    .ring_indicator_second_port_n(ri_c),
    .carrier_detect_second_port_n(dcd_c),
    .receive_data_second_or_ir_in(rxd_c),
    .data_set_ready_second_port_n(dsr_c),
    .clear_to_send_second_port_n(cts_c)
  );

  // GPIO input keeps seeing the pad in every mode; direction is the host's job on GPIO pins, fixed by the route on serial pins
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pad_out_reg <= `AFS_PAD_RESET;
      pad_oe_reg <= `AFS_PAD_RESET;
      gpio_in_reg <= `AFS_PIN_IDLE;
      {ri_reg, dcd_reg, rxd_reg, dsr_reg, cts_reg} <= `AFS_SER_IDLE;
    end else if (clk_en) begin
      pad_out_reg <= route_out;
      pad_oe_reg <= route_oe;
      gpio_in_reg <= pad_lvl_reg;
      {ri_reg, dcd_reg, rxd_reg, dsr_reg, cts_reg} <= {ri_c, dcd_c, rxd_c, dsr_c, cts_c};
    end
  end

  assign pad_out = pad_out_reg;
  assign pad_oe = pad_oe_reg;
  assign gpio_in = gpio_in_reg;
  assign ring_indicator_second_port_n = ri_reg;
  assign carrier_detect_second_port_n = dcd_reg;
  assign receive_data_second_or_ir_in = rxd_reg;
  assign data_set_ready_second_port_n = dsr_reg;
  assign clear_to_send_second_port_n = cts_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  chk_low_write: assert property (
    clk_en && cfg_state && data_wr && idx_reg == `AFS_IDX_SEL9
      |=> sel9_reg == $past(wr_data))
    else $error("low select write lost");

  chk_high_write: assert property (
    clk_en && cfg_state && data_wr && idx_reg == `AFS_IDX_SEL10
      |=> sel10_reg == $past(wr_data))
    else $error("high select write lost");

  chk_closed_guard: assert property (
    !cfg_state || !data_wr |=> $stable(sel9_reg) && $stable(sel10_reg))
    else $error("select changed outside config access");

  chk_low_route: assert property (
    clk_en && sel9_reg[5:4] == 2'h1 |=> !pad_oe_reg[2] && rxd_reg == $past(pad_lvl_reg[2]))
    else $error("receive pin not routed");

  chk_high_route: assert property (
    clk_en && sel10_reg[3:2] == 2'h1
      |=> pad_oe_reg[5] && pad_out_reg[5] == $past(request_to_send_second_port_n))
    else $error("rts pin not routed");

  chk_reset_gpio: assert property (@(posedge clock) disable iff (1'b0)
    sys_rst |=> sel9_reg == 8'h00 && sel10_reg == 8'h00 && pad_oe_reg == 8'h00)
    else $error("select not cleared by reset");

  chk_read_back: assert property (
    clk_en && data_rd && cfg_state && idx_reg == `AFS_IDX_SEL10
      |=> rd_valid && rd_hit && rd_data == $past(sel10_reg))
    else $error("high select readback wrong");

  chk_reserved_gpio: assert property (
    clk_en && sel9_reg[1] |=> pad_out_reg[0] == $past(gpio_out[0])
      && pad_oe_reg[0] == $past(gpio_oe[0]) && ri_reg)
    else $error("reserved code left GPIO");

  cov_low_alt: cover property (clk_en && cfg_state && data_wr && hit9 && wr_data == 8'h55);
  cov_high_alt: cover property (clk_en && data_wr && hit10 ##2 pad_oe_reg[7]);
  cov_readback: cover property (rd_valid && rd_hit);
  cov_reserved: cover property (sel10_reg[7:6] == 2'h3);

endmodule

// *** src/afs_consts.svh ***
`ifndef AFS_CONSTS_SVH
`define AFS_CONSTS_SVH

// Configuration index values of the two select registers
`define AFS_IDX_SEL9 8'h4c
`define AFS_IDX_SEL10 8'h4d

// Reset values of index and select registers
`define AFS_SEL_RESET 8'h00
`define AFS_IDX_RESET 8'h00

// Read value for an index this block does not own
`define AFS_RD_NONE 8'h00

// Pads float and serial inputs sit idle high until the first enabled cycle
`define AFS_PIN_IDLE 8'hff
`define AFS_SER_IDLE 5'h1f
`define AFS_PAD_RESET 8'h00

// Bit position of the low bit of each pin's field inside its register
`define AFS_FIELD_POS0 0
`define AFS_FIELD_POS1 2
`define AFS_FIELD_POS2 4
`define AFS_FIELD_POS3 6

`endif

// *** src/afs_pkg.sv ***
package afs_pkg;

  // Two-bit field code: only 01 picks the serial function
  typedef enum logic [1:0] {
    AFS_GPIO = 2'h0,
    AFS_ALT = 2'h1,
    AFS_RSV2 = 2'h2,
    AFS_RSV3 = 2'h3
  } afs_code_t;

  typedef logic [7:0] afs_byte_t;

  // Pin p (0..7) of port 5; fields of pins 0-3 in the low register, 4-7 in the high
  function automatic logic afs_is_alt(input afs_byte_t low_sel, input afs_byte_t high_sel,
                                      input int unsigned p);
    afs_byte_t r;
    logic [1:0] f;
    r = (p < 4) ? low_sel : high_sel;
    f = r[2 * (p % 4) +: 2];
    return afs_code_t'(f) == AFS_ALT;
  endfunction

endpackage

// *** src/afs_pin_route.sv ***
`timescale 1ns/10ps
// Combinational steering between GPIO logic, second serial port and the pads
module afs_pin_route (
  input wire afs_pkg::afs_byte_t low_sel,
  input wire afs_pkg::afs_byte_t high_sel,
  input wire logic [7:0] gpio_out,
  input wire logic [7:0] gpio_oe,
  input wire logic [7:0] pad_level,
  input wire logic transmit_data_second_or_ir_out,
  input wire logic request_to_send_second_port_n,
  input wire logic terminal_ready_second_port_n,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe,
  output logic ring_indicator_second_port_n,
  output logic carrier_detect_second_port_n,
  output logic receive_data_second_or_ir_in,
  output logic data_set_ready_second_port_n,
  output logic clear_to_send_second_port_n
);
  import afs_pkg::*;

  logic [7:0] alt;
  logic [7:0] uart_drv;

  always_comb begin
    for (int p = 0; p < 8; p++) begin
      alt[p] = afs_is_alt(low_sel, high_sel, p);
    end
    uart_drv = 8'h00;
    uart_drv[3] = transmit_data_second_or_ir_out;
    uart_drv[5] = request_to_send_second_port_n;
    uart_drv[7] = terminal_ready_second_port_n;
  end

  always_comb begin
    for (int p = 0; p < 8; p++) begin
      // Reserved codes fall through to GPIO, same as 00
      pad_out[p] = alt[p] ? uart_drv[p] : gpio_out[p];
    end
    // Serial outputs sit on pins 3, 5, 7; serial inputs never drive the pad
    pad_oe = (gpio_oe & ~alt) | (alt & 8'ha8);
    // Unselected serial inputs rest at their idle high level
    ring_indicator_second_port_n = alt[0] ? pad_level[0] : 1'b1;
    carrier_detect_second_port_n = alt[1] ? pad_level[1] : 1'b1;
    receive_data_second_or_ir_in = alt[2] ? pad_level[2] : 1'b1;
    data_set_ready_second_port_n = alt[4] ? pad_level[4] : 1'b1;
    clear_to_send_second_port_n = alt[6] ? pad_level[6] : 1'b1;
  end

endmodule

// *** sim/afs_pin_select_tb.sv ***
`timescale 1ns/10ps
`include "afs_consts.svh"
module afs_pin_select_tb;
  import afs_pkg::*;
  logic clock = 1'b0;
  logic clk_en = 1'b1;
  logic sys_rst = 1'b1;
  logic cfg_state = 1'b1;
  logic idx_wr = 1'b0;
  logic data_wr = 1'b0;
  logic data_rd = 1'b0;
  afs_byte_t wr_data = 8'h00;
  afs_byte_t rd_data;
  logic rd_valid;
  logic rd_hit;
  logic [7:0] gpio_out = 8'h33;
  logic [7:0] gpio_oe = 8'h5a;
  logic [7:0] gpio_in;
  logic [7:0] pad_in = 8'h00;
  logic [7:0] pad_out;
  logic [7:0] pad_oe;
  logic txd_out = 1'b1;
  logic rts_n = 1'b0;
  logic dtr_n = 1'b1;
  // Serial inputs as {cts, dsr, rx, dcd, ri}
  wire [4:0] ser_in;
  int bad_count = 0;
  int total_checks = 0;

  afs_pin_select afs_pin_select_inst (
    .clock(clock),
    .clk_en(clk_en),
    .sys_rst(sys_rst),
    .cfg_state(cfg_state),
    .idx_wr(idx_wr),
    .data_wr(data_wr),
    .data_rd(data_rd),
    .wr_data(wr_data),
    .rd_data(rd_data),
    .rd_valid(rd_valid),
    .rd_hit(rd_hit),
    .gpio_out(gpio_out),
    .gpio_oe(gpio_oe),
    .gpio_in(gpio_in),
    .pad_in(pad_in),
    .pad_out(pad_out),
    .pad_oe(pad_oe),
    .transmit_data_second_or_ir_out(txd_out),
    .request_to_send_second_port_n(rts_n),
    .terminal_ready_second_port_n(dtr_n),
    .ring_indicator_second_port_n(ser_in[0]),
    .carrier_detect_second_port_n(ser_in[1]),
    .receive_data_second_or_ir_in(ser_in[2]),
    .data_set_ready_second_port_n(ser_in[3]),
    .clear_to_send_second_port_n(ser_in[4])
  );

  always #5 clock = ~clock;

  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Strobes rise after one edge and drop after the next, where they are taken
  task automatic idx_put(input afs_byte_t v);
    @(posedge clock);
    idx_wr <= 1'b1;
    wr_data <= v;
    @(posedge clock);
    idx_wr <= 1'b0;
  endtask

  task automatic dat_put(input afs_byte_t v);
    @(posedge clock);
    data_wr <= 1'b1;
    wr_data <= v;
    @(posedge clock);
    data_wr <= 1'b0;
  endtask

  task automatic dat_get(output afs_byte_t d, output logic v, output logic h);
    @(posedge clock);
    data_rd <= 1'b1;
    @(posedge clock);
    data_rd <= 1'b0;
    #1;
    d = rd_data;
    v = rd_valid;
    h = rd_hit;
  endtask

  task automatic rd_chk(input afs_byte_t i, input afs_byte_t e, input logic hit);
    afs_byte_t d;
    logic v;
    logic h;
    idx_put(i);
    dat_get(d, v, h);
    check({7'h00, v}, 8'h01, "read valid");
    check({7'h00, h}, {7'h00, hit}, "read hit");
    check(d, e, "read data");
  endtask

  task automatic set_sel(input afs_byte_t lo, input afs_byte_t hi);
    idx_put(`AFS_IDX_SEL9);
    dat_put(lo);
    idx_put(`AFS_IDX_SEL10);
    dat_put(hi);
    // Covers the registered routing and the input filter
    repeat (8) @(posedge clock);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    repeat (8) @(posedge clock);
    #1;
    check(pad_oe, gpio_oe, "reset pad enable");
    check(pad_out, gpio_out, "reset pad drive");
    check({3'h0, ser_in}, 8'h1f, "reset serial inputs");
    check(gpio_in, pad_in, "gpio input follows pad");
    rd_chk(`AFS_IDX_SEL9, 8'h00, 1'b1);
    rd_chk(`AFS_IDX_SEL10, 8'h00, 1'b1);
  endtask

  task automatic t_access;
    afs_byte_t d;
    logic v;
    logic h;
    set_sel(8'hc6, 8'h39);
    @(posedge clock);
    cfg_state <= 1'b0;
    idx_put(`AFS_IDX_SEL9);
    dat_put(8'hff);
    dat_get(d, v, h);
    check({7'h00, v}, 8'h00, "read outside config state");
    @(posedge clock);
    cfg_state <= 1'b1;
    clk_en <= 1'b0;
    dat_put(8'h00);
    clk_en <= 1'b1;
    idx_put(8'h4e);
    dat_put(8'hff);
    dat_get(d, v, h);
    check({6'h00, v, h}, 8'h02, "foreign index answer");
    check(d, 8'h00, "foreign index data");
    rd_chk(`AFS_IDX_SEL9, 8'hc6, 1'b1);
    rd_chk(`AFS_IDX_SEL10, 8'h39, 1'b1);
  endtask

  task automatic t_route;
    logic [7:0] oe_e;
    logic [7:0] out_e;
    logic [4:0] in_e;
    afs_byte_t f;
    for (int c = 0; c < 4; c++) begin
      for (int p = 0; p < 8; p++) begin
        f = afs_byte_t'(c) << (2 * (p % 4));
        if (p < 4) set_sel(f, 8'h00);
        else set_sel(8'h00, f);
        oe_e = gpio_oe;
        out_e = gpio_out;
        in_e = 5'h1f;
        if (c == 1) begin
          oe_e[p] = (p == 3 || p == 5 || p == 7);
          if (p == 3) out_e[3] = txd_out;
          if (p == 5) out_e[5] = rts_n;
          if (p == 7) out_e[7] = dtr_n;
          if (p < 3) in_e[p] = pad_in[p];
          if (p == 4) in_e[3] = pad_in[4];
          if (p == 6) in_e[4] = pad_in[6];
        end
        check(pad_oe, oe_e, "pad enable");
        check(pad_out & oe_e, out_e & oe_e, "pad drive");
        check({3'h0, ser_in}, {3'h0, in_e}, "serial inputs");
        if (p < 4) rd_chk(`AFS_IDX_SEL9, f, 1'b1);
        if (c == 1) begin
          // Host now points the GPIO direction the way the function needs
          @(posedge clock);
          gpio_oe[p] <= oe_e[p];
          repeat (2) @(posedge clock);
          #1;
          check(pad_oe, oe_e, "pad enable after host direction");
        end
      end
    end
  endtask

  // A one-cycle pad pulse must never reach the GPIO input; a held level must
  task automatic t_glitch;
    @(posedge clock);
    pad_in <= 8'hff;
    @(posedge clock);
    pad_in <= 8'h00;
    for (int n = 0; n < 6; n++) begin
      @(posedge clock);
      #1;
      check(gpio_in, 8'h00, "pad pulse filtered");
    end
    @(posedge clock);
    pad_in <= 8'hff;
    repeat (6) @(posedge clock);
    #1;
    check(gpio_in, 8'hff, "pad level taken");
  endtask

  task automatic t_rereset;
    set_sel(8'h55, 8'h55);
    @(posedge clock);
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    rd_chk(`AFS_IDX_SEL9, 8'h00, 1'b1);
    rd_chk(`AFS_IDX_SEL10, 8'h00, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_access();
    t_route();
    t_rereset();
    t_glitch();
    final_report();
  end

  // Whole run is about 700 cycles
  initial begin
    #100000;
    bad_count++;
    final_report();
  end
endmodule
